/* File: verif/rqfd_host.sv */
// Host model: reads the receive queue and drives the register port
`timescale 1ns/1ps
module rqfd_host (
    // Clock
    input wire logic core_clk,
    // Register port
    output logic [3:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Queue read port
    output logic [11:0] q_addr,
    input wire logic [15:0] q_data
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        q_addr = 12'h000;
    end
    // Released lines flip so a stale value is never mistaken for data
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge core_clk);
        d = reg_rdata;
    endtask
    task automatic q_read(input logic [11:0] a, output logic [15:0] d);
        @(posedge core_clk);
        q_addr <= a;
        @(posedge core_clk);
        @(posedge core_clk);
        d = q_data;
    endtask
endmodule

/* File: verif/tb.sv */
// Self-checking testbench for the receive queue framer
`timescale 1ns/1ps
`include "rqfd_cfg.svh"
module tb;
    import rqfd_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic rx_sof = 1'b0;
    logic rx_valid = 1'b0;
    logic rx_eof = 1'b0;
    logic rx_crc_bad = 1'b0;
    logic rx_runt = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [15:0] q_data;
    logic reg_wr;
    logic reg_rd;
    logic frame_done;
    logic frame_dropped;
    logic [11:0] q_addr;
    int miscompares = 0;
    int num_checks = 0;
    always #25 core_clk = ~core_clk;
    rqfd_top #(.AW(12)) DUT (.core_clk(core_clk), .reset(reset), .rx_sof(rx_sof),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eof(rx_eof), .rx_crc_bad(rx_crc_bad),
        .rx_runt(rx_runt), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .q_addr(q_addr), .q_data(q_data),
        .frame_done(frame_done), .frame_dropped(frame_dropped));
    rqfd_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .q_addr(q_addr),
        .q_data(q_data));
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Wire order: DA high byte first, SA, type high then low, payload
    function automatic logic [7:0] fbyte(input logic [47:0] da, input logic [15:0] tl,
        input int i);
        if (i < 6) return da[47 - 8 * i -: 8];
        if (i < 12) return 8'hA0 + 8'(i);
        if (i == 12) return tl[15:8];
        if (i == 13) return tl[7:0];
        return 8'(i * 7);
    endfunction
    task automatic send(input logic [47:0] da, input logic [15:0] tl, input int len,
        input logic crc, input logic runt);
        @(posedge core_clk);
        rx_sof <= 1'b1;
        @(posedge core_clk);
        rx_sof <= 1'b0;
        for (int i = 0; i < len; i++) begin
            rx_valid <= 1'b1;
            rx_byte <= fbyte(da, tl, i);
            @(posedge core_clk);
        end
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        rx_eof <= 1'b1;
        rx_crc_bad <= crc;
        rx_runt <= runt;
        @(posedge core_clk);
        rx_eof <= 1'b0;
        rx_crc_bad <= 1'b0;
        rx_runt <= 1'b0;
    endtask
    // Watches both events over a fixed window so a missing drop is seen too
    task automatic wait_end(output logic done, output logic drop);
        done = 1'b0;
        drop = 1'b0;
        repeat (20) begin
            @(posedge core_clk);
            // Toggles, so a repeated pulse reads as a miss
            if (frame_done === 1'b1) done = ~done;
            if (frame_dropped === 1'b1) drop = 1'b1;
        end
    endtask
    task automatic run(input string name, input logic [47:0] da, input logic [15:0] tl,
        input int len, input logic crc, input logic runt, input logic strip,
        input logic pass, input logic hold);
        logic [15:0] st;
        logic [15:0] w;
        logic [15:0] e;
        logic done;
        logic drop;
        int cnt;
        host.reg_write(`RQFD_REG_CTRL, {14'h0000, pass, strip});
        send(da, tl, len, crc, runt);
        wait_end(done, drop);
        cnt = strip ? len - 4 : len;
        st = {1'b1, 7'h00, &da, da[40], ~da[40], 1'b0, ~runt & (tl > 16'h05DC),
            len > 1518, runt, crc};
        if ((crc | runt | (len > 1518)) & ~pass) begin
            check(drop, 1'b1, "drop event");
            check(done, 1'b0, "no entry");
            host.reg_read(`RQFD_REG_STATUS, w);
            check(w[15], 1'b0, "withheld frame valid");
        end else begin
            check(done, 1'b1, "entry event");
            host.q_read(12'h000, w);
            check(w, st, "status word");
            host.q_read(12'h002, w);
            check(w, {5'h00, 11'(cnt)}, "count word");
            for (int k = 0; 2 * k < cnt; k++) begin
                host.q_read(12'(4 + 2 * k), w);
                e = {(2 * k + 1 < cnt) ? fbyte(da, tl, 2 * k + 1) : 8'h00, fbyte(da, tl, 2 * k)};
                check(w, e, "data word");
            end
            host.reg_read(`RQFD_REG_STATUS, w);
            check(w, st, "status register");
            host.reg_read(`RQFD_REG_COUNT, w);
            check(w, {5'h00, 11'(cnt)}, "count register");
            if (hold) begin
                send(48'hFFFF_FFFF_FFFF, 16'h0800, 64, 1'b1, 1'b1);
                wait_end(done, drop);
                check({done, drop}, 2'b00, "held entry event");
                host.q_read(12'h000, w);
                check(w, st, "held status word");
            end
            host.reg_write(`RQFD_REG_CTRL, {13'h0000, 1'b1, pass, strip});
            host.reg_read(`RQFD_REG_STATUS, w);
            check(w[15], 1'b0, "released valid");
        end
        $display("test %s done", name);
    endtask
    initial begin
        #(20000 * 50);
        miscompares++;
        print_verdict();
    end
    initial begin
        logic [15:0] w;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        host.reg_read(`RQFD_REG_CTRL, w);
        check(w, 16'h0001, "control reset");
        host.reg_read(`RQFD_REG_STATUS, w);
        check(w, 16'h0000, "status reset");
        host.reg_read(4'hF, w);
        check(w, 16'h0000, "unmapped read");
        $display("test reset done");
        run("ucast_type", 48'h0211_2233_4455, 16'h0800, 64, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        run("bcast_keep", 48'hFFFF_FFFF_FFFF, 16'h002E, 69, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        run("mcast_crc_drop", 48'h0100_5E00_0001, 16'h05DD, 64, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        run("mcast_crc_pass", 48'h0100_5E00_0001, 16'h05DC, 64, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        run("runt_pass", 48'h0211_2233_4455, 16'h0800, 40, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
        run("runt_drop", 48'h0211_2233_4455, 16'h0800, 40, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        run("long_pass", 48'h0211_2233_4455, 16'h0800, 1522, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        run("long_drop", 48'h0211_2233_4455, 16'h0800, 1522, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        print_verdict();
    end
endmodule

/* File: verilog/rqfd_addr_class.sv */
// Destination address classifier and length checks
`timescale 1ns/1ps
`include "rqfd_cfg.svh"
module rqfd_addr_class
    import rqfd_pkg::*;
(
    // Frame facts
    input wire logic [47:0] dest_addr,
    input wire logic [15:0] type_len,
    input wire logic [10:0] byte_count,
    // Classes
    output logic is_bcast,
    output logic is_mcast,
    output logic is_ucast,
    output logic is_type,
    output logic is_long
);
    // First address bit on the wire is the group bit
    assign is_bcast = &dest_addr; // RULE7
    assign is_mcast = dest_addr[40]; // RULE8
    assign is_ucast = ~dest_addr[40]; // RULE9
    assign is_type = type_len > `RQFD_TYPE_LIMIT; // RULE10
    assign is_long = byte_count > `RQFD_LONG_LIMIT; // RULE11
endmodule

/* File: verilog/rqfd_cfg.svh */
// Constants for the receive queue frame descriptor block
// What this block does
// RULE1: Status at 0, count at 2, data from 4
// RULE2: Strip CRC when stripping enabled, else keep
// RULE3: Count in bits 10..0, max 1916 bytes; code stops byte-pair writes at 1916 (a trailing odd byte is still written) but the count saturates at 2047
// RULE4: Status word describes the frame held
// RULE5: Status register mirrors current frame status
// RULE6: Bit 15 valid only when frame complete
// RULE7: Bit 7 marks broadcast destination
// RULE8: Bit 6 marks multicast, broadcast included
// RULE9: Bit 5 marks unicast destination
// RULE10: Bit 3 set when type above 1500; code clears bit 3 on runt frames
// RULE11: Bit 2 set above 1518, no truncation
// RULE12: Bad frames kept only with pass-bad set
// RULE13: Bit 1 marks runt or collision damage
// RULE14: Bit 0 marks CRC failure
// RULE15: Reserved bits written as zero
`ifndef RQFD_CFG_SVH
`define RQFD_CFG_SVH
// ****************************************
// Entry layout, byte offsets
// ****************************************
`define RQFD_OFS_STATUS 12'h000
`define RQFD_OFS_COUNT 12'h002
`define RQFD_OFS_DATA 12'h004
// ****************************************
// Status word bit positions
// ****************************************
`define RQFD_BIT_VALID 15
`define RQFD_BIT_BCAST 7
`define RQFD_BIT_MCAST 6
`define RQFD_BIT_UCAST 5
`define RQFD_BIT_TYPE 3
`define RQFD_BIT_LONG 2
`define RQFD_BIT_RUNT 1
`define RQFD_BIT_CRC 0
// ****************************************
// Lengths
// ****************************************
`define RQFD_MAX_COUNT 11'h077C
`define RQFD_TYPE_LIMIT 16'h05DC
`define RQFD_LONG_LIMIT 11'h05EE
`define RQFD_CRC_BYTES 11'h0004
`define RQFD_COUNT_W 11
`define RQFD_RESET_STATUS 16'h0000
// ****************************************
// Register port offsets
// ****************************************
`define RQFD_REG_CTRL 4'h0
`define RQFD_REG_STATUS 4'h1
`define RQFD_REG_COUNT 4'h2
`define RQFD_CTRL_STRIP 0
`define RQFD_CTRL_PASSBAD 1
`define RQFD_CTRL_RELEASE 2
`endif

/* File: verilog/rqfd_mem_if.sv */
// Write channel from the framer into queue memory
`timescale 1ns/1ps
interface rqfd_mem_if #(parameter int AW = 12);
    logic we;
    logic [AW-1:0] addr;
    logic [15:0] data;
    modport src (output we, addr, data);
    modport dst (input we, addr, data);
endinterface

/* File: verilog/rqfd_pkg.sv */
// Types for the receive queue frame descriptor block
package rqfd_pkg;
    typedef enum logic [1:0] {
        RQFD_IDLE,
        RQFD_RECV,
        RQFD_STATUS,
        RQFD_COUNT
    } rqfd_state_t;
    typedef logic [15:0] rqfd_word_t;
endpackage

/* File: verilog/rqfd_queue_mem.sv */
// Flip-flop receive queue memory with a host read port
`timescale 1ns/1ps
module rqfd_queue_mem
    import rqfd_pkg::*;
#(
    parameter int AW = 12
) (
    // Clock
    input wire logic core_clk,
    // Write side
    rqfd_mem_if.dst wr,
    // Host read side
    input wire logic [AW-1:0] rd_addr,
    output rqfd_word_t rd_data
);
    localparam int WORDS = 2 ** (AW - 1);
    rqfd_word_t mem_reg [WORDS];
    rqfd_word_t rd_data_reg;
    wire [AW-2:0] wr_index = wr.addr[AW-1:1];
    wire [AW-2:0] rd_index = rd_addr[AW-1:1];
    always_ff @(posedge core_clk) begin
        if (wr.we) begin
            mem_reg[wr_index] <= wr.data;
        end
        rd_data_reg <= mem_reg[rd_index];
    end
    assign rd_data = rd_data_reg;
endmodule

/* File: verilog/rqfd_top.sv */
// Receive queue framer: builds status, count and data entries
`timescale 1ns/1ps
`include "rqfd_cfg.svh"
module rqfd_top
    import rqfd_pkg::*;
#(
    parameter int AW = 12
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // MAC receive byte stream
    input wire logic rx_sof,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_eof,
    input wire logic rx_crc_bad,
    input wire logic rx_runt,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Queue read port
    input wire logic [AW-1:0] q_addr,
    output logic [15:0] q_data,
    // Frame events
    output logic frame_done,
    output logic frame_dropped
);
    // ****************************************
    // State
    // ****************************************
    rqfd_state_t state_reg, state_next;
    logic strip_reg, passbad_reg;
    logic [10:0] count_reg;
    logic [47:0] da_reg;
    logic [15:0] tl_reg;
    logic [7:0] lo_reg;
    logic crc_reg, runt_reg;
    rqfd_word_t status_reg;
    logic [10:0] final_count_reg;
    logic [15:0] rdata_reg;
    logic done_reg, drop_reg, count_due_reg;
    logic bcast, mcast, ucast, ftype, flong;
    rqfd_mem_if #(.AW(AW)) wr_ch ();

    rqfd_addr_class u_class (
        .dest_addr(da_reg),
        .type_len(tl_reg),
        .byte_count(count_reg),
        .is_bcast(bcast),
        .is_mcast(mcast),
        .is_ucast(ucast),
        .is_type(ftype),
        .is_long(flong)
    );
    rqfd_queue_mem #(.AW(AW)) u_mem (
        .core_clk(core_clk),
        .wr(wr_ch),
        .rd_addr(q_addr),
        .rd_data(q_data)
    );

    // ****************************************
    // Decode
    // ****************************************
    wire byte_in = (state_reg == RQFD_RECV) && rx_valid;
    wire frame_end = (state_reg == RQFD_RECV) && rx_eof;
    wire [10:0] crc_adj = strip_reg ? `RQFD_CRC_BYTES : 11'h0000;
    // Count includes CRC only when stripping is disabled
    wire [10:0] stored_count = (count_reg > crc_adj) ? count_reg - crc_adj : 11'h0000; // RULE2
    wire bad = flong | runt_reg | crc_reg | rx_crc_bad | rx_runt;
    wire keep = ~bad | passbad_reg; // RULE12
    wire [11:0] data_ofs = {1'b0, count_reg} + `RQFD_OFS_DATA;
    wire data_room = count_reg < `RQFD_MAX_COUNT;
    // Stripped CRC bytes land past the count and are simply never read
    wire write_pair = byte_in && count_reg[0] && data_room; // RULE1
    rqfd_word_t status_word;
    assign status_word = {1'b1, 7'h00, bcast, mcast, ucast, 1'b0, ftype & ~(runt_reg | rx_runt),
        flong, runt_reg | rx_runt, crc_reg | rx_crc_bad}; // RULE15
    wire release_wr = reg_wr && reg_addr == `RQFD_REG_CTRL && reg_wdata[`RQFD_CTRL_RELEASE];

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RQFD_IDLE: begin
                if (rx_sof) begin
                    state_next = RQFD_RECV;
                end
            end
            RQFD_RECV: begin
                if (rx_eof) begin
                    state_next = keep ? RQFD_STATUS : RQFD_IDLE;
                end
            end
            RQFD_STATUS: begin
                state_next = RQFD_COUNT;
            end
            RQFD_COUNT: begin
                if (release_wr) begin
                    state_next = RQFD_IDLE;
                end
            end
        endcase
    end

    // ****************************************
    // Memory writes
    // ****************************************
    always_comb begin
        wr_ch.we = 1'b0;
        wr_ch.addr = '0;
        wr_ch.data = 16'h0000;
        if (write_pair) begin
            wr_ch.we = 1'b1;
            wr_ch.addr = data_ofs[AW-1:0] - AW'(1);
            wr_ch.data = {rx_byte, lo_reg};
        end else if (frame_end && count_reg[0] && keep) begin
            wr_ch.we = 1'b1;
            wr_ch.addr = data_ofs[AW-1:0];
            wr_ch.data = {8'h00, lo_reg};
        end else if (state_reg == RQFD_STATUS) begin
            wr_ch.we = 1'b1;
            wr_ch.addr = AW'(`RQFD_OFS_STATUS); // RULE1
            wr_ch.data = status_reg; // RULE4
        end else if (state_reg == RQFD_COUNT && status_reg[`RQFD_BIT_VALID] &&
                     count_due_reg) begin
            wr_ch.we = 1'b1;
            wr_ch.addr = AW'(`RQFD_OFS_COUNT); // RULE1
            wr_ch.data = {5'h00, final_count_reg}; // RULE3
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= RQFD_IDLE;
            strip_reg <= 1'b1;
            passbad_reg <= 1'b0;
            count_reg <= 11'h000;
            da_reg <= 48'h0;
            tl_reg <= 16'h0000;
            lo_reg <= 8'h00;
            crc_reg <= 1'b0;
            runt_reg <= 1'b0;
            status_reg <= `RQFD_RESET_STATUS;
            final_count_reg <= 11'h000;
        end else begin
            state_reg <= state_next;
            if (reg_wr && reg_addr == `RQFD_REG_CTRL) begin
                strip_reg <= reg_wdata[`RQFD_CTRL_STRIP];
                passbad_reg <= reg_wdata[`RQFD_CTRL_PASSBAD];
            end
            if (state_reg == RQFD_IDLE && rx_sof) begin
                count_reg <= 11'h000;
                crc_reg <= 1'b0;
                runt_reg <= 1'b0;
                da_reg <= 48'h0;
                tl_reg <= 16'h0000;
                status_reg <= `RQFD_RESET_STATUS; // RULE6
            end
            if (byte_in) begin
                if (count_reg != 11'h7FF) begin
                    count_reg <= count_reg + 11'h001; // RULE11
                end
                lo_reg <= rx_byte;
                if (count_reg < 11'd6) begin
                    da_reg <= {da_reg[39:0], rx_byte};
                end
                if (count_reg == 11'd12 || count_reg == 11'd13) begin
                    tl_reg <= {tl_reg[7:0], rx_byte};
                end
            end
            if (frame_end) begin
                crc_reg <= rx_crc_bad; // RULE14
                runt_reg <= rx_runt; // RULE13
                if (keep) begin
                    status_reg <= status_word; // RULE5
                    final_count_reg <= stored_count;
                end
            end
            if (state_next == RQFD_IDLE && state_reg == RQFD_COUNT) begin
                status_reg <= `RQFD_RESET_STATUS; // RULE6
            end
        end
    end

    // ****************************************
    // Events and register read
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            done_reg <= 1'b0;
            drop_reg <= 1'b0;
            count_due_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            // First held cycle only, so a long hold never repeats the event
            count_due_reg <= state_reg == RQFD_STATUS;
            done_reg <= count_due_reg;
            drop_reg <= frame_end && !keep; // RULE12
            rdata_reg <= 16'h0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    `RQFD_REG_CTRL: rdata_reg <= {14'h0000, passbad_reg, strip_reg};
                    `RQFD_REG_STATUS: rdata_reg <= status_reg; // RULE5
                    `RQFD_REG_COUNT: rdata_reg <= {5'h00, final_count_reg};
                    default: rdata_reg <= 16'h0000;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_reg;
    assign frame_done = done_reg;
    assign frame_dropped = drop_reg;

    // ****************************************
    // Checks
    // ****************************************
    property p_valid_after_status;
        @(posedge core_clk) disable iff (reset)
        state_reg == RQFD_STATUS |=> status_reg[`RQFD_BIT_VALID];
    endproperty
    a_valid_after_status: assert property (p_valid_after_status) // RULE6
        else $error("Valid bit missing after frame");
    property p_invalid_recv;
        @(posedge core_clk) disable iff (reset)
        state_reg == RQFD_RECV && !rx_eof |=> !status_reg[`RQFD_BIT_VALID];
    endproperty
    a_invalid_recv: assert property (p_invalid_recv) // RULE6
        else $error("Valid bit set while receiving");
    property p_bcast_mcast;
        @(posedge core_clk) disable iff (reset)
        status_reg[`RQFD_BIT_BCAST] |-> status_reg[`RQFD_BIT_MCAST];
    endproperty
    a_bcast_mcast: assert property (p_bcast_mcast) // RULE8
        else $error("Broadcast without multicast");
    property p_ucast_excl;
        @(posedge core_clk) disable iff (reset)
        status_reg[`RQFD_BIT_VALID] |-> status_reg[`RQFD_BIT_UCAST] != status_reg[`RQFD_BIT_MCAST];
    endproperty
    a_ucast_excl: assert property (p_ucast_excl) // RULE9
        else $error("Unicast and multicast disagree");
    property p_reserved_zero;
        @(posedge core_clk) disable iff (reset)
        status_reg[14:8] == 7'h00 && status_reg[4] == 1'b0 && final_count_reg <= `RQFD_MAX_COUNT;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // RULE15
        else $error("Reserved status bits set");
    property p_drop_bad;
        @(posedge core_clk) disable iff (reset)
        frame_end && bad && !passbad_reg |=> state_reg == RQFD_IDLE ##0 frame_dropped;
    endproperty
    a_drop_bad: assert property (p_drop_bad) // RULE12
        else $error("Bad frame not withheld");
    property p_crc_flag;
        @(posedge core_clk) disable iff (reset)
        frame_end && keep |=> status_reg[`RQFD_BIT_CRC] == $past(rx_crc_bad);
    endproperty
    a_crc_flag: assert property (p_crc_flag) // RULE14
        else $error("CRC flag wrong");
    property p_count_word;
        @(posedge core_clk) disable iff (reset)
        state_reg == RQFD_STATUS |=> wr_ch.we && wr_ch.addr == AW'(`RQFD_OFS_COUNT)
            && wr_ch.data[10:0] == final_count_reg;
    endproperty
    a_count_word: assert property (p_count_word) // RULE3
        else $error("Count word not written");
    property p_status_addr;
        @(posedge core_clk) disable iff (reset)
        state_reg == RQFD_STATUS |-> wr_ch.we && wr_ch.addr == AW'(`RQFD_OFS_STATUS);
    endproperty
    a_status_addr: assert property (p_status_addr) // RULE1
        else $error("Status word misplaced");
    c_good_frame: cover property (@(posedge core_clk) disable iff (reset)
        state_reg == RQFD_STATUS ##1 state_reg == RQFD_COUNT);
    c_dropped: cover property (@(posedge core_clk) disable iff (reset) frame_dropped);
    c_long: cover property (@(posedge core_clk) disable iff (reset)
        status_reg[`RQFD_BIT_LONG]);
endmodule
